// ===== design/fccr_pkg.sv
/*
 * Constants shared by the card command front end: register offsets, field
 * positions, operation codes and engine states.
 * Assumes a 32-bit register port with byte offsets and a 20 MHz bus clock.
 */
// Contract
// - CRC enable set: lowest sixteen transmitted bits replaced by computed CRC.
// - Operation code 0x44 means wait for read data, checked packet.
// - Operation code 0x06 or 0x26 means write data to the card.
// - Operation code 0x00 means receive a handshake from the card.
// - Operation code 0x08 means wait until the card stops signalling busy.
// - Writing the bit count starts exchanging that many bits.
// - Bit count reads back bits remaining, counts down, resets to zero.
// - Next bus state bit sets the level driven on the bus state pin.
// - After receive, status shows CRC pass; data packets only are checked.
// - Last transmit word carries its bits from bit 31 down; low padding replaced by CRC.
package fccr_pkg;

    // ------------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------------
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFS_CMD_ONE  = 8'h00;
    localparam logic [7:0]  OFS_CMD_TWO  = 8'h04;
    localparam logic [7:0]  OFS_TX_DATA  = 8'h08;
    localparam logic [7:0]  OFS_RX_DATA  = 8'h0C;
    localparam logic [7:0]  OFS_STATUS   = 8'h10;
    localparam logic [7:0]  OFS_INT_STAT = 8'h14;
    localparam logic [7:0]  OFS_INT_MASK = 8'h18;

    // ------------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------------
    localparam int          COUNT_LSB    = 0;
    localparam int          COUNT_MSB    = 15;
    localparam int          OP_LSB       = 16;
    localparam int          OP_MSB       = 22;
    localparam int          NBS_BIT      = 20;
    localparam int          CRC_BIT      = 21;
    localparam int          WIDE_BIT     = 22;
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] CRC_TAIL     = 16'h0010;
    localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
    localparam logic [3:0]  INT_RESET    = 4'h0;

    // ------------------------------------------------------------------------
    // Operation codes in bits 22:16 of command register one
    // ------------------------------------------------------------------------
    localparam logic [6:0]  OP_READ_WAIT = 7'h44;
    localparam logic [6:0]  OP_WRITE_W   = 7'h06;
    localparam logic [6:0]  OP_WRITE_N   = 7'h26;
    localparam logic [6:0]  OP_HANDSHAKE = 7'h00;
    localparam logic [6:0]  OP_BUSY_WAIT = 7'h08;

    // ------------------------------------------------------------------------
    // Interrupt bits and engine states
    // ------------------------------------------------------------------------
    localparam int          INT_DONE     = 0;
    localparam int          INT_RX_FULL  = 1;
    localparam int          INT_TX_EMPTY = 2;
    localparam int          INT_CRC_FAIL = 3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFER = 2'b01,
        ST_BUSY = 2'b10
    } fccr_state_t;

endpackage : fccr_pkg

// ===== design/fccr_crc16.sv
/*
 * One serial CRC-16 lane: feeds packet bits, or drains its remainder MSB first.
 * Assumes feed and drain are never high together.
 */
`timescale 1ns/10ps
module fccr_crc16 #(
    parameter logic [15:0] POLY = 16'h1021
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Control
    input  wire logic        clr,
    input  wire logic        feed,
    input  wire logic        drain,
    input  wire logic        bit_in,
    // Remainder
    output logic [15:0]      crc_q
);
    logic        fb;
    logic [15:0] crc_d;

    assign fb    = crc_q[15] ^ bit_in;
    assign crc_d = drain ? {crc_q[14:0], 1'b0}
                 : feed  ? ({crc_q[14:0], 1'b0} ^ (fb ? POLY : 16'h0000))
                 : crc_q;

    always_ff @(posedge clk) begin
        if (rst || clr) begin
            crc_q <= 16'h0000;
        end else begin
            crc_q <= crc_d;
        end
    end
endmodule : fccr_crc16

// ===== design/fccr_top.sv
/*
 * Command register front end of the flash card serial link with its shift
 * engine, transmit and receive word registers, status and interrupt.
 * Assumes the card clock and card inputs are asynchronous to clk and slower
 * than clk by at least four to one.
 */
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module fccr_top (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // Register port
    input  wire logic [fccr_pkg::ADDR_W-1:0] addr,
    input  wire logic [31:0]               wdata,
    input  wire logic                      wr,
    input  wire logic                      rd,
    output logic      [31:0]               rdata,
    // Card link
    input  wire logic                      card_clk,
    input  wire logic                      cmd_in,
    input  wire logic [3:0]                dat_in,
    output logic      [3:0]                dat_out,
    output logic      [3:0]                dat_oe_n,
    output logic                           bus_state_pin,
    // Interrupt
    output logic                           irq
);
    // ------------------------------------------------------------------------
    // Synchronisers and card clock edge
    // ------------------------------------------------------------------------
    logic [5:0] sync1_q, sync2_q;
    logic       clk_old_q;
    logic       edge_s, cmd_s;
    logic [3:0] dat_s;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q   <= 6'h00;
            sync2_q   <= 6'h00;
            clk_old_q <= 1'b0;
        end else begin
            sync1_q   <= {card_clk, cmd_in, dat_in};
            sync2_q   <= sync1_q;
            clk_old_q <= sync2_q[5];
        end
    end

    assign edge_s = sync2_q[5] & ~clk_old_q;
    assign cmd_s  = sync2_q[4];
    assign dat_s  = sync2_q[3:0];

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    fccr_pkg::fccr_state_t state_q, state_d;
    logic [6:0]  op_q;
    logic        crc_en_q, wide_q, nbs_q;
    logic [15:0] count_q;
    logic        wr_one, wr_two, wr_tx, rd_rx, rd_int, wr_mask;
    logic [6:0]  op_new;
    logic        op_ok, start;

    assign wr_one  = wr && addr == fccr_pkg::OFS_CMD_ONE;
    assign wr_two  = wr && addr == fccr_pkg::OFS_CMD_TWO;
    assign wr_tx   = wr && addr == fccr_pkg::OFS_TX_DATA;
    assign wr_mask = wr && addr == fccr_pkg::OFS_INT_MASK;
    assign rd_rx   = rd && addr == fccr_pkg::OFS_RX_DATA;
    assign rd_int  = rd && addr == fccr_pkg::OFS_INT_STAT;
    assign op_new  = wr_one ? wdata[fccr_pkg::OP_MSB:fccr_pkg::OP_LSB] : op_q;
    assign op_ok   = op_new == fccr_pkg::OP_READ_WAIT || op_new == fccr_pkg::OP_WRITE_W ||
                     op_new == fccr_pkg::OP_WRITE_N || op_new == fccr_pkg::OP_HANDSHAKE ||
                     op_new == fccr_pkg::OP_BUSY_WAIT;
    assign start   = (wr_one || wr_two) && state_q == fccr_pkg::ST_IDLE && op_ok &&
                     (wdata[fccr_pkg::COUNT_MSB:fccr_pkg::COUNT_LSB] != 16'h0000 ||
                      op_new == fccr_pkg::OP_BUSY_WAIT);

    // ------------------------------------------------------------------------
    // Operation decode and step sizes
    // ------------------------------------------------------------------------
    logic        is_tx, is_rd, is_hs, is_bw, xfer;
    logic [15:0] step;
    logic [5:0]  step6, word_bits;
    logic        in_crc, last_step;

    assign is_rd     = op_q == fccr_pkg::OP_READ_WAIT;
    assign is_tx     = op_q == fccr_pkg::OP_WRITE_W || op_q == fccr_pkg::OP_WRITE_N;
    assign is_hs     = op_q == fccr_pkg::OP_HANDSHAKE;
    assign is_bw     = op_q == fccr_pkg::OP_BUSY_WAIT;
    assign xfer      = state_q == fccr_pkg::ST_XFER;
    assign step      = wide_q ? 16'h0004 : 16'h0001;
    assign step6     = step[5:0];
    assign last_step = count_q <= step;
    assign in_crc    = crc_en_q && count_q <= fccr_pkg::CRC_TAIL;
    assign word_bits = count_q[4:0] == 5'h00 ? 6'h20 : {1'b0, count_q[4:0]};

    // ------------------------------------------------------------------------
    // Shift register and word buffers
    // ------------------------------------------------------------------------
    logic [31:0] tx_q, rx_q, sr_q, sr_d;
    logic [5:0]  sr_bits_q, sr_bits_d;
    logic        tx_full_q, rx_full_q;
    logic        tx_load, tx_shift, rx_shift, word_done;
    logic [3:0]  rx_bits, lane_out;
    logic [15:0] count_d;

    assign tx_load   = xfer && is_tx && sr_bits_q == 6'h00 && tx_full_q;
    assign tx_shift  = xfer && is_tx && edge_s && sr_bits_q != 6'h00;
    assign rx_shift  = xfer && (is_rd || is_hs) && edge_s && !rx_full_q;
    assign rx_bits   = wide_q ? dat_s : {3'b000, is_hs ? cmd_s : dat_s[0]};
    assign word_done = rx_shift && (sr_bits_q + step6 == 6'h20 || last_step);
    assign count_d   = last_step ? 16'h0000 : count_q - step;
    assign sr_d      = tx_load ? tx_q
                     : (tx_shift || rx_shift) ? (wide_q ? {sr_q[27:0], rx_bits} : {sr_q[30:0], rx_bits[0]})
                     : sr_q;
    assign sr_bits_d = tx_load ? word_bits
                     : tx_shift ? sr_bits_q - step6
                     : word_done ? 6'h00
                     : rx_shift ? sr_bits_q + step6
                     : sr_bits_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            sr_q      <= fccr_pkg::WORD_RESET;
            sr_bits_q <= 6'h00;
        end else begin
            sr_q      <= start ? fccr_pkg::WORD_RESET : sr_d;
            sr_bits_q <= start ? 6'h00 : sr_bits_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_q      <= fccr_pkg::WORD_RESET;
            tx_full_q <= 1'b0;
            rx_q      <= fccr_pkg::WORD_RESET;
            rx_full_q <= 1'b0;
        end else begin
            tx_q      <= wr_tx ? wdata : tx_q;
            tx_full_q <= wr_tx || (tx_full_q && !tx_load);
            rx_q      <= word_done ? sr_d : rx_q;
            rx_full_q <= word_done || (rx_full_q && !rd_rx);
        end
    end

    // ------------------------------------------------------------------------
    // CRC lanes: one per data line, lane 0 only on the narrow bus
    // ------------------------------------------------------------------------
    logic [15:0] crc_q [4];
    logic [3:0]  crc_zero;

    assign lane_out = wide_q ? sr_q[31:28] : {3'b111, sr_q[31]};

    for (genvar i = 0; i < 4; i++) begin : g_crc
        fccr_crc16 u_crc (
            .clk    (clk),
            .rst    (rst),
            .clr    (start),
            .feed   ((tx_shift && !in_crc) || (rx_shift && is_rd)),
            .drain  (tx_shift && in_crc),
            .bit_in (tx_shift ? lane_out[i] : rx_bits[i]),
            .crc_q  (crc_q[i])
        );
        assign crc_zero[i] = crc_q[i] == 16'h0000 || (!wide_q && i != 0);
    end

    // ------------------------------------------------------------------------
    // Command registers and engine state
    // ------------------------------------------------------------------------
    logic chk_pend_q, crc_ok_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            fccr_pkg::ST_IDLE: begin
                if (start) begin
                    state_d = op_new == fccr_pkg::OP_BUSY_WAIT ? fccr_pkg::ST_BUSY : fccr_pkg::ST_XFER;
                end
            end
            fccr_pkg::ST_XFER: begin
                if ((tx_shift || rx_shift) && last_step) begin
                    state_d = fccr_pkg::ST_IDLE;
                end
            end
            fccr_pkg::ST_BUSY: begin
                if (dat_s[0]) begin
                    state_d = fccr_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = fccr_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q  <= fccr_pkg::ST_IDLE;
            op_q     <= fccr_pkg::OP_HANDSHAKE;
            crc_en_q <= 1'b0;
            wide_q   <= 1'b0;
            nbs_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            if (wr_one && state_q == fccr_pkg::ST_IDLE) begin
                op_q     <= op_new;
                crc_en_q <= wdata[fccr_pkg::CRC_BIT];
                wide_q   <= wdata[fccr_pkg::WIDE_BIT];
            end
            if (wr_two) begin
                nbs_q <= wdata[fccr_pkg::NBS_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= fccr_pkg::COUNT_RESET;
        end else if (start) begin
            count_q <= wdata[fccr_pkg::COUNT_MSB:fccr_pkg::COUNT_LSB];
        end else if (tx_shift || rx_shift) begin
            count_q <= count_d;
        end else if (state_q == fccr_pkg::ST_BUSY && dat_s[0]) begin
            count_q <= fccr_pkg::COUNT_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            chk_pend_q <= 1'b0;
            crc_ok_q   <= 1'b0;
        end else begin
            chk_pend_q <= rx_shift && last_step && is_rd;
            if (chk_pend_q) begin
                crc_ok_q <= &crc_zero;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Card pins
    // ------------------------------------------------------------------------
    logic [3:0] crc_msb;
    logic       tx_drive;

    assign crc_msb  = {crc_q[3][15], crc_q[2][15], crc_q[1][15], crc_q[0][15]};
    assign tx_drive = xfer && is_tx;

    always_ff @(posedge clk) begin
        if (rst) begin
            dat_out       <= 4'hF;
            dat_oe_n      <= 4'hF;
            bus_state_pin <= 1'b0;
        end else begin
            if (tx_shift) begin
                dat_out <= in_crc ? crc_msb : lane_out;
            end
            dat_oe_n <= tx_drive ? (wide_q ? 4'h0 : 4'hE) : 4'hF;
            if (start) begin
                bus_state_pin <= wr_two ? wdata[fccr_pkg::NBS_BIT] : nbs_q;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Status, interrupts and read data
    // ------------------------------------------------------------------------
    logic       busy, busy_old_q, rx_old_q, tx_old_q;
    logic [3:0] int_stat_q, int_mask_q, events;
    logic [31:0] status, cmd_rd, rd_d;

    assign busy   = state_q != fccr_pkg::ST_IDLE || chk_pend_q;
    assign events = {chk_pend_q && !(&crc_zero), tx_old_q && !tx_full_q,
                     rx_full_q && !rx_old_q, busy_old_q && !busy};
    assign status = {26'h0, rx_full_q, tx_full_q, state_q == fccr_pkg::ST_BUSY, 1'b0, busy, crc_ok_q};
    assign cmd_rd = {9'h000, wide_q, crc_en_q, nbs_q, op_q[3:0], count_q};
    assign rd_d   = addr == fccr_pkg::OFS_CMD_ONE  ? {9'h000, op_q, count_q}
                  : addr == fccr_pkg::OFS_CMD_TWO  ? {cmd_rd[31:22], 1'b0, cmd_rd[20:0]}
                  : addr == fccr_pkg::OFS_RX_DATA  ? rx_q
                  : addr == fccr_pkg::OFS_STATUS   ? status
                  : addr == fccr_pkg::OFS_INT_STAT ? {28'h0, int_stat_q}
                  : addr == fccr_pkg::OFS_INT_MASK ? {28'h0, int_mask_q}
                  : 32'h0000_0000;
    assign irq    = |(int_stat_q & int_mask_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_old_q <= 1'b0;
            rx_old_q   <= 1'b0;
            tx_old_q   <= 1'b0;
            int_stat_q <= fccr_pkg::INT_RESET;
            int_mask_q <= fccr_pkg::INT_RESET;
            rdata      <= 32'h0000_0000;
        end else begin
            busy_old_q <= busy;
            rx_old_q   <= rx_full_q;
            tx_old_q   <= tx_full_q;
            int_stat_q <= (rd_int ? 4'h0 : int_stat_q) | events;
            int_mask_q <= wr_mask ? wdata[3:0] : int_mask_q;
            rdata      <= rd ? rd_d : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_start_busy;
        @(posedge clk) disable iff (rst) start |=> busy ##0 !(state_q == fccr_pkg::ST_IDLE);
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start did not leave idle");

    property p_count_read;
        @(posedge clk) disable iff (rst) (rd && addr == fccr_pkg::OFS_CMD_TWO) |=> rdata[15:0] == $past(count_q);
    endproperty
    a_count_read: assert property (p_count_read) else $error("bit count read mismatch");

    property p_count_down;
        @(posedge clk) disable iff (rst) (xfer && !start) |=> count_q <= $past(count_q);
    endproperty
    a_count_down: assert property (p_count_down) else $error("bit count rose during transfer");

    property p_bs_pin;
        @(posedge clk) disable iff (rst) (start && wr_two) |=> bus_state_pin == $past(wdata[fccr_pkg::NBS_BIT]);
    endproperty
    a_bs_pin: assert property (p_bs_pin) else $error("bus state pin wrong");

    property p_crc_out;
        @(posedge clk) disable iff (rst) (tx_shift && in_crc) |=> dat_out[0] == $past(crc_q[0][15]);
    endproperty
    a_crc_out: assert property (p_crc_out) else $error("CRC bit not driven");

    property p_data_out;
        @(posedge clk) disable iff (rst) (tx_shift && !in_crc && !wide_q) |=> dat_out[0] == $past(sr_q[31]);
    endproperty
    a_data_out: assert property (p_data_out) else $error("data bit not driven");

    property p_narrow;
        @(posedge clk) disable iff (rst) (xfer && !wide_q) ##1 (xfer && !wide_q) |-> dat_oe_n[3:1] == 3'b111;
    endproperty
    a_narrow: assert property (p_narrow) else $error("upper lanes driven on narrow bus");

    property p_busy_end;
        @(posedge clk) disable iff (rst) (state_q == fccr_pkg::ST_BUSY && dat_s[0]) |=> state_q == fccr_pkg::ST_IDLE;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy wait did not end");

    property p_hs_nocheck;
        @(posedge clk) disable iff (rst) (xfer && is_hs) |=> $stable(crc_ok_q);
    endproperty
    a_hs_nocheck: assert property (p_hs_nocheck) else $error("handshake changed CRC status");

    property p_hs_quiet;
        @(posedge clk) disable iff (rst) (xfer && is_hs) |=> dat_oe_n == 4'hF;
    endproperty
    a_hs_quiet: assert property (p_hs_quiet) else $error("handshake drove data lines");

    property p_rd_quiet;
        @(posedge clk) disable iff (rst) (xfer && is_rd) |=> dat_oe_n == 4'hF;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read wait drove data lines");

    property p_tx_drive;
        @(posedge clk) disable iff (rst) (xfer && is_tx) |=> dat_oe_n[0] == 1'b0;
    endproperty
    a_tx_drive: assert property (p_tx_drive) else $error("write did not drive lane 0");

    c_tx_crc: cover property (@(posedge clk) disable iff (rst) tx_shift && in_crc);
    c_rx_pass: cover property (@(posedge clk) disable iff (rst) chk_pend_q && (&crc_zero));
    c_busy_wait: cover property (@(posedge clk) disable iff (rst) state_q == fccr_pkg::ST_BUSY ##1 !busy);
    c_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq));
endmodule : fccr_top

// ===== tb/fccr_card_model.sv
/* Card model: makes the card clock inside frames only and drives command and data lines.
   Assumes the bench opens and closes each frame through en. */
`timescale 1ns/10ps
module fccr_card_model (
    // Bench control
    input  wire logic        en,
    input  wire logic        wide,
    input  wire logic        busy,
    input  wire logic [31:0] pat,
    // Card pins
    input  wire logic [3:0]  dat_out,
    output logic             card_clk,
    output logic             cmd_in,
    output logic [3:0]       dat_in,
    output logic [31:0]      cap
);
    logic [31:0] sh;

    // The clock stands low between frames; bits change on the falling edge.
    initial begin
        card_clk = 1'h0;
        sh = 32'h0000_0000;
        cap = 32'h0000_0000;
        forever begin
            @(posedge en);
            #13;
            sh = pat;
            while (en) begin
                #200 card_clk = 1'h1;
                cap = {cap[30:0], dat_out[0]};
                #200 card_clk = 1'h0;
                sh = wide ? sh << 4 : sh << 1;
            end
        end
    end

    // Released lines float to their pull-up level; a low on lane 0 means busy.
    assign cmd_in = en ? sh[31] : 1'h1;
    assign dat_in = busy ? 4'hE : ((en && wide) ? sh[31:28] : 4'hF);
endmodule : fccr_card_model

// ===== tb/fccr_top_test.sv
/* Bench for the card command front end: register port tasks and card frames.
   Assumes the card model on the card pins and a 20 MHz bus clock. */
`timescale 1ns/10ps
module fccr_top_test;
    logic        clk, rst, wr, rd, en, wide, busy;
    logic        card_clk, cmd_in, bus_state_pin, irq;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, pat, cap, got;
    logic [3:0]  dat_in, dat_out, dat_oe_n;
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc = 0;

    fccr_top dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .card_clk(card_clk), .cmd_in(cmd_in), .dat_in(dat_in), .dat_out(dat_out), .dat_oe_n(dat_oe_n),
        .bus_state_pin(bus_state_pin), .irq(irq));
    fccr_card_model card_u (.en(en), .wide(wide), .busy(busy), .pat(pat), .dat_out(dat_out),
        .card_clk(card_clk), .cmd_in(cmd_in), .dat_in(dat_in), .cap(cap));

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            $display("mismatch at %0t: run hung", $time);
            conclude();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
        n_compared++;
        if ((g & m) !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g & m, e);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wr_reg

    // The read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 got = rdata;
    endtask : rd_reg

    task automatic card_on(input logic [31:0] p, input logic w);
        @(posedge clk);
        pat <= p;
        wide <= w;
        en <= 1'h1;
    endtask : card_on

    task automatic card_off;
        en <= 1'h0;
        repeat (10) @(posedge clk);
    endtask : card_off

    // Opens a frame of n card clock rises; eight bus clocks make one card period.
    task automatic card_run(input logic [31:0] p, input logic w, input int n);
        card_on(p, w);
        repeat (n * 8 - 1) @(posedge clk);
        card_off();
    endtask : card_run

    task automatic rx_case(input logic [31:0] p, input logic pass);
        wr_reg(fccr_pkg::OFS_CMD_ONE, 32'h0044_0020);
        card_run(p, 1'h1, 8);
        rd_reg(fccr_pkg::OFS_STATUS);
        chk(got, {31'h0, pass}, 32'h0000_0003);
        rd_reg(fccr_pkg::OFS_RX_DATA);
        chk(got, p, 32'hFFFF_FFFF);
        rd_reg(fccr_pkg::OFS_INT_STAT);
        chk(got, pass ? 32'h0 : 32'h8, 32'h0000_0008);
    endtask : rx_case

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        {rst, wr, rd, en, wide, busy} = 6'h20;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        pat = 32'h0000_0000;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd_reg(fccr_pkg::OFS_CMD_ONE);
        chk(got, 32'h0, 32'hFFFF_FFFF);
        rd_reg(fccr_pkg::OFS_CMD_TWO);
        chk(got, 32'h0, 32'hFFFF_FFFF);
        chk({28'h0, dat_oe_n}, 32'hF, 32'hF);
        rd_reg(8'h1C);
        chk(got, 32'h0, 32'hFFFF_FFFF);
        // Two narrow bits, both inside the CRC tail, with the bus state level raised.
        wr_reg(fccr_pkg::OFS_CMD_ONE, 32'h0026_0000);
        wr_reg(fccr_pkg::OFS_TX_DATA, 32'h4000_0000);
        wr_reg(fccr_pkg::OFS_CMD_TWO, 32'h0016_0002);
        card_on(32'h0, 1'h0);
        repeat (8) @(posedge clk);
        rd_reg(fccr_pkg::OFS_CMD_TWO);
        chk(got, 32'h1, 32'hFFFF);
        chk({28'h0, dat_oe_n}, 32'hE, 32'hF);
        repeat (13) @(posedge clk);
        card_off();
        chk(cap, 32'h4, 32'h7);
        rd_reg(fccr_pkg::OFS_CMD_TWO);
        chk(got, 32'h0016_0000, 32'h0077_FFFF);
        chk({31'h0, bus_state_pin}, 32'h1, 32'h1);
        chk({31'h0, irq}, 32'h0, 32'h1);
        wr_reg(fccr_pkg::OFS_INT_MASK, 32'h0000_0001);
        #1 chk({31'h0, irq}, 32'h1, 32'h1);
        rd_reg(fccr_pkg::OFS_INT_STAT);
        chk(got, 32'h1, 32'h1);
        chk({31'h0, irq}, 32'h0, 32'h1);
        // Two narrow data bits without CRC, started by the first command register.
        wr_reg(fccr_pkg::OFS_TX_DATA, 32'h4000_0000);
        wr_reg(fccr_pkg::OFS_CMD_ONE, 32'h0006_0002);
        card_run(32'h0, 1'h0, 3);
        chk(cap, 32'h1, 32'h3);
        // Busy wait holds until the card releases lane 0.
        busy <= 1'h1;
        wr_reg(fccr_pkg::OFS_CMD_ONE, 32'h0008_0000);
        repeat (4) @(posedge clk);
        rd_reg(fccr_pkg::OFS_STATUS);
        chk(got, 32'h8, 32'h8);
        busy <= 1'h0;
        repeat (6) @(posedge clk);
        rd_reg(fccr_pkg::OFS_STATUS);
        chk(got, 32'h0, 32'h8);
        // Handshake byte on the command line.
        wr_reg(fccr_pkg::OFS_CMD_ONE, 32'h0000_0008);
        card_run(32'hA500_0000, 1'h0, 8);
        rd_reg(fccr_pkg::OFS_RX_DATA);
        chk(got, 32'h0000_00A5, 32'hFFFF_FFFF);
        rd_reg(fccr_pkg::OFS_CMD_ONE);
        chk(got, 32'h0, 32'hFFFF);
        rx_case(32'h0000_0000, 1'h1);
        rx_case(32'h1000_0000, 1'h0);
        conclude();
    end
endmodule : fccr_top_test
